// ===== inc/dwe_pkg.sv
// Constants and carrier types for the three-channel width-adapting DMA core
// Functional notes
// - Adapt each item between peripheral and memory widths, one read and one write.
// - Narrow source goes to low bits of destination, upper bits zero.
// - Halfword into word is zero-extended, destination steps by four.
// - Wider source into byte destination keeps only the low byte.
// - Word into halfword destination keeps low halfword, destination steps by two.
// - Source and destination addresses step independently by their own item size.
// - Byte writes replicate the byte on all four lanes, size says byte.
// - Halfword writes replicate the halfword on both halves, size says halfword.
// - A bus error response on any access is a transfer error of the active channel.
// - A transfer error in read or write phase switches the channel off.
// - A transfer error sets the error flag; interrupt only when its enable is set.
// - Each channel has half, complete and error flags with their own enables.
// - With a count of one the half flag never sets; complete sets at end.
// - Each of three channels can select any of the peripheral request lines.
// - Half flag sets at half the items moved, complete flag at count zero.
// - Enabled half, complete and error conditions are ORed into one channel interrupt.
// - Global flag sets on any event; flags clear only on a software clear pulse.
package dwe_pkg;
    localparam int NUM_CH = 3;
    localparam int NUM_REQ = 26;
    localparam int REQ_SEL_W = 5;
    localparam int CNT_W = 16;
    localparam logic [1:0] WIDTH_BYTE = 2'h0;
    localparam logic [1:0] WIDTH_HALF = 2'h1;
    localparam logic [1:0] WIDTH_WORD = 2'h2;
    localparam logic [31:0] STEP_BYTE = 32'h1;
    localparam logic [31:0] STEP_HALF = 32'h2;
    localparam logic [31:0] STEP_WORD = 32'h4;
    localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
    localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
    localparam logic [31:0] MASK_WORD = 32'hffff_ffff;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_ERROR = 1'h1;
    localparam logic [31:0] ADDR_RST = 32'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0;

    typedef struct packed {
        logic [REQ_SEL_W-1:0] req_sel;
        logic mem_to_periph;
        logic [1:0] periph_item_width;
        logic [1:0] mem_item_width;
        logic periph_addr_step_on;
        logic mem_addr_step_on;
        logic xfer_error_irq_on;
        logic half_done_irq_on;
        logic xfer_done_irq_on;
        logic [31:0] periph_addr;
        logic [31:0] mem_addr;
        logic [CNT_W-1:0] item_count;
    } dwe_cfg_type;

    typedef struct packed {
        logic chan_any_event_flag;
        logic xfer_error_flag;
        logic half_done_flag;
        logic xfer_done_flag;
    } dwe_flags_type;

    localparam dwe_flags_type FLAGS_RST = 4'h0;
endpackage

// ===== rtl/dwe_dma_core.sv
// Three-channel DMA core with width adaptation, lane replication and event flags
`timescale 1ns/1ns
module dwe_dma_core
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input dwe_pkg::dwe_cfg_type [dwe_pkg::NUM_CH-1:0] i_cfg,
    input wire logic [dwe_pkg::NUM_CH-1:0] i_chan_on_set,
    input wire logic [dwe_pkg::NUM_CH-1:0] i_chan_off,
    input dwe_pkg::dwe_flags_type [dwe_pkg::NUM_CH-1:0] i_event_clear,
    input wire logic [dwe_pkg::NUM_REQ-1:0] i_periph_req,
    input wire logic i_hready,
    input wire logic i_hresp,
    input wire logic [31:0] i_hrdata,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata,
    output logic [dwe_pkg::NUM_CH-1:0] o_chan_on,
    output dwe_pkg::dwe_flags_type [dwe_pkg::NUM_CH-1:0] o_flags,
    output logic [dwe_pkg::NUM_CH-1:0] o_chan_irq,
    output logic [dwe_pkg::NUM_CH-1:0][dwe_pkg::CNT_W-1:0] o_chan_remaining_count,
    output logic [dwe_pkg::NUM_CH-1:0] o_chan_ack
);
    import dwe_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RD_ADDR = 5'h02,
        ST_RD_DATA = 5'h04,
        ST_WR_ADDR = 5'h08,
        ST_WR_DATA = 5'h10
    } dwe_state_type;

    dwe_state_type state;
    logic [1:0] act;
    logic [NUM_CH-1:0] err_oh;
    logic [NUM_CH-1:0][31:0] cur_periph;
    logic [NUM_CH-1:0][31:0] cur_mem;
    logic [NUM_CH-1:0][CNT_W-1:0] total;
    logic [NUM_CH-1:0] pend;
    logic [1:0] grant;
    wire busy_settle = (|o_chan_ack) | (|err_oh);
    wire [NUM_CH-1:0] act_oh = NUM_CH'(3'h1 << act);
    wire dwe_cfg_type cfg_a = i_cfg[act];
    wire dwe_cfg_type cfg_g = i_cfg[grant];

    // Source and destination follow the direction bit of the channel
    wire [31:0] src_addr_g = cfg_g.mem_to_periph ? cur_mem[grant] : cur_periph[grant];
    wire [1:0] src_w_g = cfg_g.mem_to_periph ? cfg_g.mem_item_width : cfg_g.periph_item_width;
    wire [31:0] dst_addr_a = cfg_a.mem_to_periph ? cur_periph[act] : cur_mem[act];
    wire [1:0] src_w_a = cfg_a.mem_to_periph ? cfg_a.mem_item_width : cfg_a.periph_item_width;
    wire [1:0] dst_w_a = cfg_a.mem_to_periph ? cfg_a.periph_item_width : cfg_a.mem_item_width;

    // Pick the item out of its byte lane, then keep only the source width
    wire [31:0] rd_shift = i_hrdata >> {o_haddr[1:0], 3'h0};
    wire [31:0] src_mask = (src_w_a == WIDTH_BYTE) ? MASK_BYTE :
                           (src_w_a == WIDTH_HALF) ? MASK_HALF : MASK_WORD;
    wire [31:0] item = rd_shift & src_mask;
    wire [31:0] next_wdata = (dst_w_a == WIDTH_BYTE) ? {4{item[7:0]}} :
                             (dst_w_a == WIDTH_HALF) ? {2{item[15:0]}} :
                             item;

    wire acc_done = i_hready;
    wire acc_err = i_hready & (i_hresp == HRESP_ERROR);

    // Fixed priority toward the lowest channel number
    always_comb
    begin
        grant = 2'h0;
        for (int k = NUM_CH - 1; k >= 0; k--)
        begin
            if (pend[k])
            begin
                grant = 2'(k);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            act <= 2'h0;
            o_haddr <= ADDR_RST;
            o_htrans <= HTRANS_IDLE;
            o_hwrite <= 1'h0;
            o_hsize <= 3'h0;
            o_hwdata <= ADDR_RST;
            o_chan_ack <= '0;
            err_oh <= '0;
        end
        else
        begin
            o_chan_ack <= '0;
            err_oh <= '0;
            unique case (state)
                ST_IDLE:
                begin
                    // Wait for the channel registers to settle after an item
                    if ((|pend) && !busy_settle)
                    begin
                        act <= grant;
                        o_haddr <= src_addr_g;
                        o_htrans <= HTRANS_NONSEQ;
                        o_hwrite <= 1'h0;
                        o_hsize <= {1'h0, src_w_g};
                        state <= ST_RD_ADDR;
                    end
                end
                ST_RD_ADDR:
                begin
                    if (acc_done)
                    begin
                        o_htrans <= HTRANS_IDLE;
                        state <= ST_RD_DATA;
                    end
                end
                ST_RD_DATA:
                begin
                    if (acc_err)
                    begin
                        err_oh <= act_oh;
                        state <= ST_IDLE;
                    end
                    else if (acc_done)
                    begin
                        o_haddr <= dst_addr_a;
                        o_htrans <= HTRANS_NONSEQ;
                        o_hwrite <= 1'h1;
                        o_hsize <= {1'h0, dst_w_a};
                        o_hwdata <= next_wdata;
                        state <= ST_WR_ADDR;
                    end
                end
                ST_WR_ADDR:
                begin
                    if (acc_done)
                    begin
                        o_htrans <= HTRANS_IDLE;
                        state <= ST_WR_DATA;
                    end
                end
                ST_WR_DATA:
                begin
                    if (acc_err)
                    begin
                        err_oh <= act_oh;
                        state <= ST_IDLE;
                    end
                    else if (acc_done)
                    begin
                        o_chan_ack <= act_oh;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_chan
            wire dwe_cfg_type cfg = i_cfg[c];
            wire item_ok = o_chan_ack[c];
            wire err = err_oh[c];
            // Out-of-range selections never request
            wire req = (cfg.req_sel < REQ_SEL_W'(NUM_REQ)) ? i_periph_req[cfg.req_sel] : 1'h0;
            wire [CNT_W-1:0] next_remain = o_chan_remaining_count[c] - CNT_ONE;
            wire [31:0] p_step = !cfg.periph_addr_step_on ? ADDR_RST :
                                 (cfg.periph_item_width == WIDTH_BYTE) ? STEP_BYTE :
                                 (cfg.periph_item_width == WIDTH_HALF) ? STEP_HALF : STEP_WORD;
            wire [31:0] m_step = !cfg.mem_addr_step_on ? ADDR_RST :
                                 (cfg.mem_item_width == WIDTH_BYTE) ? STEP_BYTE :
                                 (cfg.mem_item_width == WIDTH_HALF) ? STEP_HALF : STEP_WORD;
            wire last = item_ok & (next_remain == CNT_ZERO);
            wire half_set = item_ok & (total[c] != CNT_ONE) &
                            (next_remain == (total[c] >> 1));
            dwe_flags_type set_ev;
            dwe_flags_type next_flags;
            assign set_ev.xfer_error_flag = err;
            assign set_ev.half_done_flag = half_set;
            assign set_ev.xfer_done_flag = last;
            assign set_ev.chan_any_event_flag = err | half_set | last;
            // Set wins over a clear arriving in the same cycle
            assign next_flags = (o_flags[c] & ~i_event_clear[c]) | set_ev;
            assign pend[c] = o_chan_on[c] & req;

            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    o_chan_on[c] <= 1'h0;
                    cur_periph[c] <= ADDR_RST;
                    cur_mem[c] <= ADDR_RST;
                    total[c] <= CNT_RST;
                    o_chan_remaining_count[c] <= CNT_RST;
                    o_flags[c] <= FLAGS_RST;
                    o_chan_irq[c] <= 1'h0;
                end
                else
                begin
                    o_flags[c] <= next_flags;
                    o_chan_irq[c] <= (next_flags.xfer_error_flag & cfg.xfer_error_irq_on) |
                                     (next_flags.half_done_flag & cfg.half_done_irq_on) |
                                     (next_flags.xfer_done_flag & cfg.xfer_done_irq_on);
                    if (i_chan_on_set[c] && !o_chan_on[c])
                    begin
                        // A zero count never starts the channel
                        o_chan_on[c] <= (cfg.item_count != CNT_ZERO);
                        cur_periph[c] <= cfg.periph_addr;
                        cur_mem[c] <= cfg.mem_addr;
                        total[c] <= cfg.item_count;
                        o_chan_remaining_count[c] <= cfg.item_count;
                    end
                    else
                    begin
                        if (err || i_chan_off[c] || last)
                        begin
                            o_chan_on[c] <= 1'h0;
                        end
                        if (item_ok)
                        begin
                            o_chan_remaining_count[c] <= next_remain;
                            cur_periph[c] <= cur_periph[c] + p_step;
                            cur_mem[c] <= cur_mem[c] + m_step;
                        end
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== bench/dwe_dma_core_props.sv
// Port checks for the width-adapting DMA core
`timescale 1ns/1ns
module dwe_dma_core_props
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input dwe_pkg::dwe_cfg_type [dwe_pkg::NUM_CH-1:0] i_cfg,
    input wire logic i_hready,
    input wire logic i_hresp,
    input wire logic [1:0] o_htrans,
    input wire logic o_hwrite,
    input wire logic [2:0] o_hsize,
    input wire logic [31:0] o_hwdata,
    input wire logic [dwe_pkg::NUM_CH-1:0] o_chan_on,
    input dwe_pkg::dwe_flags_type [dwe_pkg::NUM_CH-1:0] o_flags,
    input wire logic [dwe_pkg::NUM_CH-1:0] o_chan_irq,
    input wire logic [dwe_pkg::NUM_CH-1:0][dwe_pkg::CNT_W-1:0] o_chan_remaining_count,
    input wire logic [dwe_pkg::NUM_CH-1:0] o_chan_ack
);
    import dwe_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire wr_addr = o_htrans == HTRANS_NONSEQ && o_hwrite;
    sequence s_rd_addr;
        o_htrans == HTRANS_NONSEQ && !o_hwrite && i_hready;
    endsequence
    sequence s_rd_err;
        s_rd_addr ##1 (!i_hready && i_hresp) ##1 (i_hready && i_hresp);
    endsequence
    property p_byte_lanes;
        wr_addr && o_hsize == 3'h0 |-> o_hwdata == {4{o_hwdata[7:0]}};
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes");
    property p_half_lanes;
        wr_addr && o_hsize == 3'h1 |-> o_hwdata == {2{o_hwdata[15:0]}};
    endproperty
    a_half_lanes: assert property (p_half_lanes) else $error("half lanes");
    property p_rd_wr;
        s_rd_addr ##1 (i_hready && !i_hresp) |=> wr_addr;
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("no write after read");
    // A failed read must never leak into a write of stale data
    property p_rd_err;
        s_rd_err |=> (!wr_addr) [*4];
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("write after read error");
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        property p_err_off;
            $rose(o_flags[c].xfer_error_flag) |-> o_flags[c].chan_any_event_flag
                ##[0:1] !o_chan_on[c];
        endproperty
        a_err_off: assert property (p_err_off) else $error("error kept on");
        property p_irq;
            o_chan_irq[c] == (o_flags[c].xfer_error_flag && $past(i_cfg[c].xfer_error_irq_on)
                || o_flags[c].half_done_flag && $past(i_cfg[c].half_done_irq_on)
                || o_flags[c].xfer_done_flag && $past(i_cfg[c].xfer_done_irq_on));
        endproperty
        a_irq: assert property (p_irq) else $error("irq mismatch");
        property p_ack_dec;
            o_chan_ack[c] |=> o_chan_remaining_count[c] ==
                $past(o_chan_remaining_count[c]) - 16'h1;
        endproperty
        a_ack_dec: assert property (p_ack_dec) else $error("count step");
        property p_half;
            $rose(o_flags[c].half_done_flag) |-> i_cfg[c].item_count != CNT_ONE &&
                o_chan_remaining_count[c] == i_cfg[c].item_count >> 1;
        endproperty
        a_half: assert property (p_half) else $error("half point");
    end
endmodule

// ===== bench/dwe_mem_model.sv
// Memory slave with optional wait state and an erroring top region
`timescale 1ns/1ns
module dwe_mem_model
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    output logic o_hready,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    logic [31:0] mem [0:63];
    logic [31:0] a, junk;
    logic ph, wr, waited;
    logic [2:0] sz;
    wire bad = a[31:28] == 4'hf;
    // Bridge-like region ignores the size and stores the whole word lane set
    wire wide = a[31:28] == 4'h4;
    assign o_hready = !(ph && (bad || i_slow) && !waited);
    assign o_hresp = ph && bad;
    // Idle read data moves every cycle so a late sample cannot pass by luck
    assign o_hrdata = ph && !wr ? mem[a[7:2]] : junk;
    initial
        for (int b = 0; b < 256; b++)
            mem[b / 4][8 * (b % 4) +: 8] = 8'(b) ^ 8'h5a;
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ph <= 1'b0;
            waited <= 1'b0;
            junk <= 32'h0;
        end
        else
        begin
            junk <= junk + 32'h9e37_79b9;
            waited <= ph && !o_hready;
            if (ph && o_hready)
                ph <= 1'b0;
            if (i_htrans == 2'h2 && o_hready)
                ph <= 1'b1;
            if (i_htrans == 2'h2 && o_hready)
                {a, wr, sz} <= {i_haddr, i_hwrite, i_hsize};
            if (ph && o_hready && wr && !bad)
                for (int k = 0; k < 4; k++)
                    if (sz == 3'h2 || wide || (sz[0] ? k / 2 == a[1] : k == a[1:0]))
                        mem[a[7:2]][8 * k +: 8] <= i_hwdata[8 * k +: 8];
        end
    end
endmodule

// ===== bench/dwe_dma_width_error_irq_tb.sv
// Self-checking bench for the width-adapting DMA core
`timescale 1ns/1ns
module dwe_dma_width_error_irq_tb;
    import dwe_pkg::*;
    logic clk, rst_n, slow, hready, hresp, hwrite;
    dwe_cfg_type [NUM_CH-1:0] cfg;
    dwe_flags_type [NUM_CH-1:0] clr, flags;
    logic [NUM_CH-1:0] on_set, chan_off, chan_on, irq;
    logic [NUM_REQ-1:0] req;
    logic [31:0] hrdata, haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    int mismatches, num_checks;
    dwe_dma_core DUT (.i_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_chan_on_set(on_set),
        .i_chan_off(chan_off), .i_event_clear(clr), .i_periph_req(req), .i_hready(hready),
        .i_hresp(hresp), .i_hrdata(hrdata), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata), .o_chan_on(chan_on),
        .o_flags(flags), .o_chan_irq(irq), .o_chan_remaining_count(cnt), .o_chan_ack());
    dwe_mem_model u_mem (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .o_hready(hready), .o_hresp(hresp), .o_hrdata(hrdata));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [7:0] mb(input int a);
        return u_mem.mem[a / 4][8 * (a % 4) +: 8];
    endfunction
    task check(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request held until the channel drops, as a peripheral without acknowledge would
    task run(input int c, r, input logic [1:0] sw, dw, input logic [31:0] sa, da,
        input logic [15:0] n, input logic mp, ie);
        int k;
        cfg[c] = '{r[4:0], mp, mp ? dw : sw, mp ? sw : dw, 1'b1, 1'b1, ie, 1'b1, 1'b1,
            mp ? da : sa, mp ? sa : da, n};
        on_set[c] = 1'b1;
        req[r] = 1'b1;
        @(negedge clk);
        on_set[c] = 1'b0;
        k = 0;
        while (chan_on[c] === 1'b1 && k < 500)
        begin
            @(negedge clk);
            k++;
        end
        req[r] = 1'b0;
        @(negedge clk);
    endtask
    task clear(input int c);
        clr[c] = 4'hf;
        @(negedge clk);
        clr[c] = 4'h0;
        @(negedge clk);
        check("flags cleared", 32'(flags[c]), 32'h0);
        check("irq cleared", 32'(irq[c]), 32'h0);
    endtask
    task t_widths;
        int ss, ds;
        logic [31:0] e;
        for (int q = 0; q < 9; q++)
        begin
            ss = 1 << (q / 3);
            ds = 1 << (q % 3);
            slow = q[1];
            run(q % 3, q + 4, 2'(q / 3), 2'(q % 3), 32'h0, 32'h80, 16'h3, q[0], 1'b1);
            for (int i = 0; i < 3; i++)
                for (int j = 0; j < ds; j++)
                begin
                    e = j < ss ? 32'(8'(i * ss + j) ^ 8'h5a) : 32'h0;
                    check("dest byte", 32'(mb(128 + i * ds + j)), e);
                end
            check("flags", 32'(flags[q % 3]), 32'hb);
            check("irq", 32'(irq[q % 3]), 32'h1);
            clear(q % 3);
        end
    endtask
    task t_requests;
        for (int r = 0; r < NUM_REQ; r++)
        begin
            run(r % 3, r, 2'h0, 2'h0, 32'h10 + r, 32'h90 + r, 16'h1, 1'b0, 1'b0);
            check("single flags", 32'(flags[r % 3]), 32'h9);
            check("moved byte", 32'(mb(144 + r)), 32'(8'(16 + r) ^ 8'h5a));
            clear(r % 3);
        end
    endtask
    // A byte write into a size-blind slave lands as a replicated word, a halfword into word as zero-extended
    task t_bridge;
        for (int h = 0; h < 2; h++)
        begin
            run(h, 3, 2'(h), 2'(2 * h), 32'h20, 32'h4000_00a0 + 4 * h, 16'h1, h[0], 1'b0);
            for (int j = 0; j < 4; j++)
                check("wide byte", 32'(mb(160 + 4 * h + j)),
                    h ? (j < 2 ? 32'(8'(32 + j) ^ 8'h5a) : 32'h0) : 32'h7a);
            check("wide flags", 32'(flags[h]), 32'h9);
            clear(h);
        end
    endtask
    task t_errors;
        for (int e = 0; e < 2; e++)
        begin
            run(e, 2, 2'h2, 2'h2, e ? 32'h0 : 32'hf000_0000, e ? 32'hf000_0000 : 32'h80,
                16'h2, 1'b0, e == 0);
            check("error flags", 32'(flags[e]), 32'hc);
            check("error irq", 32'(irq[e]), 32'(e == 0));
            check("channel on", 32'(chan_on[e]), 32'h0);
            check("count kept", 32'(cnt[e]), 32'h2);
            clear(e);
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        slow = 1'b0;
        cfg = '0;
        on_set = '0;
        chan_off = '0;
        clr = '0;
        req = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check("reset flags", 32'(flags), 32'h0);
        t_widths;
        t_requests;
        t_bridge;
        t_errors;
        stop_test;
    end
    initial
    begin
        #(40 * 20000);
        mismatches++;
        stop_test;
    end
endmodule
bind dwe_dma_core dwe_dma_core_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
    .i_hready(i_hready), .i_hresp(i_hresp), .o_htrans(o_htrans), .o_hwrite(o_hwrite),
    .o_hsize(o_hsize), .o_hwdata(o_hwdata), .o_chan_on(o_chan_on), .o_flags(o_flags),
    .o_chan_irq(o_chan_irq), .o_chan_remaining_count(o_chan_remaining_count),
    .o_chan_ack(o_chan_ack));
